// ===== design/pcs_cmd_status.sv
// Purpose: command/status and class/revision registers of the bus interface
// Assumes: rst_n is the bus reset; error events are one-cycle pulses from bus engines
// Notes:   two access ports: configuration cycles and the combined register group
`timescale 1ns/1ps
`default_nettype none
module pcs_cmd_status
  import pcs_pkg::*;
#(
  parameter logic [7:0] REVISION_LEVEL = REVISION_DEFAULT
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pcixMode,
  // configuration-space view
  input  wire logic        cfgRead,
  input  wire logic        cfgWrite,
  input  wire logic [11:0] cfgAddr,
  input  wire logic [3:0]  cfgByteEn,
  input  wire logic [31:0] cfgWdata,
  output var  logic [31:0] cfgRdata,
  // combined register group view
  input  wire logic        grpRead,
  input  wire logic        grpWrite,
  input  wire logic [11:0] grpAddr,
  input  wire logic [3:0]  grpByteEn,
  input  wire logic [31:0] grpWdata,
  output var  logic [31:0] grpRdata,
  // error events from the bus engines
  input  wire logic        parityErrEvt,
  input  wire logic        sysErrDetect,
  input  wire logic        masterAbortEvt,
  input  wire logic        specialCycle,
  input  wire logic        targetAbortEvt,
  input  wire logic        dataParityErr,
  input  wire logic        perrSeen,
  input  wire logic        wasMaster,
  // requests from the bus engines
  input  wire logic        masterReq,
  input  wire logic        memAccessHit,
  input  wire logic        ioAccessHit,
  // controls and pins
  output var  logic        masterStartOk,
  output var  logic        memRespond,
  output var  logic        ioRespond,
  output var  logic        systemErrorOut,
  output var  logic        systemErrorOe,
  output var  logic        parityErrorOut,
  output var  logic        parityErrorOe
);
  typedef struct packed {
    logic        systemErrorEnable;
    logic        parityErrorResponse;
    logic        busMasterEnable;
    logic        memorySpaceEnable;
    logic        masterStartOk;
    logic        memRespond;
    logic        serrDrive;
    logic        perrDrive;
    logic [31:0] cfgRdata;
    logic [31:0] grpRdata;
  } pcs_state_type;

  pcs_state_type st_reg;
  pcs_state_type st_next;

  logic detectedParityError;
  logic signalledSystemError;
  logic receivedMasterAbort;
  logic receivedTargetAbort;
  logic masterDataParityError;
  logic [4:0] evtSet;
  logic [4:0] evtClr;
  logic [4:0] flagVal;
  logic cfgCmdWr;
  logic grpCmdWr;
  logic [31:0] cmdWdata;
  logic [3:0]  cmdBe;

  function automatic logic [31:0] status_word(input logic [31:0] fl, input logic pcx,
                                              input pcs_state_type s);
    logic [31:0] w;
    w = ZERO_WORD;
    w[PDET_BIT] = fl[0];
    w[SSE_BIT]  = fl[1];
    w[RMA_BIT]  = fl[2];
    w[RTA_BIT]  = fl[3];
    w[STGT_BIT] = 1'b0;
    w[DSPD1_BIT] = DECODE_SPEED_MEDIUM[1];
    w[DSPD0_BIT] = DECODE_SPEED_MEDIUM[0];
    w[MDPE_BIT] = fl[4];
    w[FBB_BIT]  = ~pcx;
    w[M66_BIT]  = 1'b1;
    w[CLIST_BIT] = 1'b1;
    w[SEE_BIT]  = s.systemErrorEnable;
    w[PER_BIT]  = s.parityErrorResponse;
    w[BME_BIT]  = s.busMasterEnable;
    w[MSE_BIT]  = s.memorySpaceEnable;
    w[IOE_BIT]  = 1'b0;
    return w;
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] a, input logic [31:0] sw);
    logic [31:0] w;
    w = ZERO_WORD;
    if (a == CMDSTS_OFFSET) begin
      w = sw;
    end else if (a == CLASSREV_OFFSET) begin
      w = {BASE_CLASS_VAL, SUB_CLASS_VAL, PROG_IF_VAL, REVISION_LEVEL};
    end
    return w;
  endfunction

  // both views decode the same offsets; config view wins a same-cycle collision
  assign cfgCmdWr = cfgWrite && (cfgAddr == CMDSTS_OFFSET);
  assign grpCmdWr = grpWrite && (grpAddr == CMDSTS_OFFSET);
  assign cmdWdata = cfgCmdWr ? cfgWdata : grpWdata;
  assign cmdBe    = cfgCmdWr ? cfgByteEn : grpByteEn;

  assign evtSet[0] = parityErrEvt;
  assign evtSet[1] = st_reg.serrDrive;
  assign evtSet[2] = masterAbortEvt && !specialCycle;
  assign evtSet[3] = targetAbortEvt;
  assign evtSet[4] = perrSeen && wasMaster && st_reg.parityErrorResponse;

  // status byte holds the clear bits; write-one-to-clear only with that lane
  assign evtClr[0] = (cfgCmdWr || grpCmdWr) && cmdBe[3] && cmdWdata[PDET_BIT];
  assign evtClr[1] = (cfgCmdWr || grpCmdWr) && cmdBe[3] && cmdWdata[SSE_BIT];
  assign evtClr[2] = (cfgCmdWr || grpCmdWr) && cmdBe[3] && cmdWdata[RMA_BIT];
  assign evtClr[3] = (cfgCmdWr || grpCmdWr) && cmdBe[3] && cmdWdata[RTA_BIT];
  assign evtClr[4] = (cfgCmdWr || grpCmdWr) && cmdBe[3] && cmdWdata[MDPE_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      pcs_flag u_flag (
        .clk     (clk),
        .rst_n   (rst_n),
        .setEvt  (evtSet[gi]),
        .clrReq  (evtClr[gi]),
        .flagOut (flagVal[gi])
      );
    end
  endgenerate

  assign detectedParityError   = flagVal[0];
  assign signalledSystemError  = flagVal[1];
  assign receivedMasterAbort   = flagVal[2];
  assign receivedTargetAbort   = flagVal[3];
  assign masterDataParityError = flagVal[4];

  always_comb begin
    logic [31:0] sw;
    sw = status_word({27'h0000000, flagVal}, pcixMode, st_reg);
    st_next = st_reg;
    // only writable command bits change; others ignored
    if ((cfgCmdWr || grpCmdWr) && cmdBe[1]) begin
      st_next.systemErrorEnable = cmdWdata[SEE_BIT];
    end
    if ((cfgCmdWr || grpCmdWr) && cmdBe[0]) begin
      st_next.parityErrorResponse = cmdWdata[PER_BIT];
      st_next.busMasterEnable     = cmdWdata[BME_BIT];
      st_next.memorySpaceEnable   = cmdWdata[MSE_BIT];
    end
    st_next.masterStartOk = masterReq && st_reg.busMasterEnable;
    st_next.memRespond    = memAccessHit && st_reg.memorySpaceEnable;
    // next enable, so a clearing write silences the pin at once
    st_next.serrDrive     = sysErrDetect && st_next.systemErrorEnable;
    st_next.perrDrive     = dataParityErr && st_next.parityErrorResponse;
    st_next.cfgRdata = cfgRead ? read_word(cfgAddr, sw) : ZERO_WORD;
    st_next.grpRdata = grpRead ? read_word(grpAddr, sw) : ZERO_WORD;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfgRdata       = st_reg.cfgRdata;
  assign grpRdata       = st_reg.grpRdata;
  assign masterStartOk  = st_reg.masterStartOk;
  assign memRespond     = st_reg.memRespond;
  assign ioRespond      = 1'b0;
  assign systemErrorOut = 1'b0;
  assign systemErrorOe  = st_reg.serrDrive;
  assign parityErrorOut = 1'b0;
  assign parityErrorOe  = st_reg.perrDrive;

  // pin gating
  a_parity_error_response_enable : assert property (@(posedge clk) disable iff (!rst_n)
    !st_reg.parityErrorResponse |-> !parityErrorOe)
    else $error("parity_error_response driven while off");
  a_parity_error_response_drive : assert property (@(posedge clk) disable iff (!rst_n)
    dataParityErr && st_reg.parityErrorResponse && !(cfgCmdWr || grpCmdWr) |=> parityErrorOe)
    else $error("parity_error_response not driven");
  a_system_error_enable_enable : assert property (@(posedge clk) disable iff (!rst_n)
    !st_reg.systemErrorEnable |-> !systemErrorOe)
    else $error("system_error_enable driven while off");
  a_system_error_enable_drive : assert property (@(posedge clk) disable iff (!rst_n)
    sysErrDetect && st_reg.systemErrorEnable && !(cfgCmdWr || grpCmdWr) |=> systemErrorOe)
    else $error("system_error_enable not driven");
  a_master_gate : assert property (@(posedge clk) disable iff (!rst_n)
    masterStartOk |-> $past(st_reg.busMasterEnable))
    else $error("master while off");
  a_master_follow : assert property (@(posedge clk) disable iff (!rst_n)
    masterReq && st_reg.busMasterEnable |=> masterStartOk)
    else $error("master start lost");
  a_mem_gate : assert property (@(posedge clk) disable iff (!rst_n)
    memRespond |-> $past(st_reg.memorySpaceEnable))
    else $error("mem answer while off");
  a_mem_follow : assert property (@(posedge clk) disable iff (!rst_n)
    memAccessHit && st_reg.memorySpaceEnable |=> memRespond)
    else $error("mem answer lost");
  a_io_never : assert property (@(posedge clk) disable iff (!rst_n)
    ioAccessHit |=> !ioRespond)
    else $error("io access answered");

  // event flags
  a_system_error_enable_flag : assert property (@(posedge clk) disable iff (!rst_n)
    systemErrorOe |=> signalledSystemError)
    else $error("system_error_enable not flagged");
  a_parity_flag : assert property (@(posedge clk) disable iff (!rst_n)
    parityErrEvt |=> detectedParityError)
    else $error("parity not flagged");
  a_abort_flag : assert property (@(posedge clk) disable iff (!rst_n)
    masterAbortEvt && !specialCycle |=> receivedMasterAbort)
    else $error("abort lost");
  a_special_skip : assert property (@(posedge clk) disable iff (!rst_n)
    !receivedMasterAbort && !(masterAbortEvt && !specialCycle) |=> !receivedMasterAbort)
    else $error("abort flagged without cause");
  a_target_flag : assert property (@(posedge clk) disable iff (!rst_n)
    targetAbortEvt |=> receivedTargetAbort)
    else $error("target abort lost");
  a_mdpe_gate : assert property (@(posedge clk) disable iff (!rst_n)
    !masterDataParityError && !(perrSeen && wasMaster && st_reg.parityErrorResponse)
    |=> !masterDataParityError)
    else $error("mdpe set without cause");
  a_flag_clear : assert property (@(posedge clk) disable iff (!rst_n)
    (evtClr & ~evtSet) != 5'h00 |=> (flagVal & $past(evtClr & ~evtSet)) == 5'h00)
    else $error("flag not cleared");
  a_flag_hold : assert property (@(posedge clk) disable iff (!rst_n)
    (flagVal & ~evtClr) != 5'h00
    |=> (flagVal & $past(flagVal & ~evtClr)) == $past(flagVal & ~evtClr))
    else $error("flag lost without clear");

  // register reads and writes
  a_class_read : assert property (@(posedge clk) disable iff (!rst_n)
    cfgRead && cfgAddr == CLASSREV_OFFSET |=> cfgRdata[31:8] == 24'h068000)
    else $error("class code wrong");
  a_group_class : assert property (@(posedge clk) disable iff (!rst_n)
    grpRead && grpAddr == CLASSREV_OFFSET
    |=> grpRdata[31:8] == {BASE_CLASS_VAL, SUB_CLASS_VAL, PROG_IF_VAL})
    else $error("group class code wrong");
  a_revision_read : assert property (@(posedge clk) disable iff (!rst_n)
    cfgRead && cfgAddr == CLASSREV_OFFSET |=> cfgRdata[7:0] == REVISION_LEVEL)
    else $error("revision wrong");
  a_fixed_bits : assert property (@(posedge clk) disable iff (!rst_n)
    grpRead && grpAddr == CMDSTS_OFFSET |=> grpRdata[27:25] == 3'h1 && grpRdata[21:20] == 2'h3
    && grpRdata[0] == 1'b0)
    else $error("fixed status bits wrong");
  a_signalled_target_abort_zero : assert property (@(posedge clk) disable iff (!rst_n)
    cfgRead && cfgAddr == CMDSTS_OFFSET |=> !cfgRdata[STGT_BIT])
    else $error("target abort bit set");
  a_fbb_mode : assert property (@(posedge clk) disable iff (!rst_n)
    cfgRead && cfgAddr == CMDSTS_OFFSET |=> cfgRdata[FBB_BIT] != $past(pcixMode))
    else $error("back-to-back bit wrong for mode");
  a_unmapped_zero : assert property (@(posedge clk) disable iff (!rst_n)
    grpRead && grpAddr != CMDSTS_OFFSET && grpAddr != CLASSREV_OFFSET |=> grpRdata == ZERO_WORD)
    else $error("unmapped read not zero");
  a_enable_write : assert property (@(posedge clk) disable iff (!rst_n)
    cfgCmdWr && cfgByteEn[0] |=> st_reg.busMasterEnable == $past(cfgWdata[BME_BIT]))
    else $error("enable write lost");

  // main scenarios
  c_system_error_enable_pin : cover property (@(posedge clk) disable iff (!rst_n) systemErrorOe);
  c_parity_error_response_pin : cover property (@(posedge clk) disable iff (!rst_n) parityErrorOe);
  c_clear_parity : cover property (@(posedge clk) disable iff (!rst_n)
    detectedParityError ##1 !detectedParityError);
  c_master : cover property (@(posedge clk) disable iff (!rst_n) masterStartOk);
  c_io_ignored : cover property (@(posedge clk) disable iff (!rst_n) ioAccessHit);
endmodule
`default_nettype wire

// ===== pkg/pcs_pkg.sv
// Purpose: constants for the configuration command/status and class/revision registers
// Assumes: 32-bit register port, registers at printed byte offsets
// Notes:   config-space view at 0x04/0x08, combined group view at 0x004/0x008
package pcs_pkg;
  localparam logic [11:0] CMDSTS_OFFSET   = 12'h004;
  localparam logic [11:0] CLASSREV_OFFSET = 12'h008;
  localparam int PDET_BIT  = 31;
  localparam int SSE_BIT   = 30;
  localparam int RMA_BIT   = 29;
  localparam int RTA_BIT   = 28;
  localparam int STGT_BIT  = 27;
  localparam int DSPD1_BIT = 26;
  localparam int DSPD0_BIT = 25;
  localparam int MDPE_BIT  = 24;
  localparam int FBB_BIT   = 23;
  localparam int M66_BIT   = 21;
  localparam int CLIST_BIT = 20;
  localparam int SEE_BIT   = 8;
  localparam int PER_BIT   = 6;
  localparam int BME_BIT   = 2;
  localparam int MSE_BIT   = 1;
  localparam int IOE_BIT   = 0;
  localparam logic [1:0] DECODE_SPEED_MEDIUM = 2'h1;
  localparam logic [7:0] BASE_CLASS_VAL      = 8'h06;
  localparam logic [7:0] SUB_CLASS_VAL       = 8'h80;
  localparam logic [7:0] PROG_IF_VAL         = 8'h00;
  // arbitrary neutral revision value
  localparam logic [7:0] REVISION_DEFAULT    = 8'h0a;
  localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;
endpackage

// ===== design/pcs_flag.sv
// Purpose: one sticky write-one-to-clear event flag
// Assumes: event and clear on the same clock
// Notes:   set wins over clear
`timescale 1ns/1ps
`default_nettype none
module pcs_flag
  import pcs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic setEvt,
  input  wire logic clrReq,
  output var  logic flagOut
);
  typedef struct packed {
    logic flag;
  } pcs_flag_state_type;
  pcs_flag_state_type st_reg;
  pcs_flag_state_type st_next;

  always_comb begin
    st_next = st_reg;
    if (setEvt) begin
      st_next.flag = 1'b1;
    end else if (clrReq) begin
      st_next.flag = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flagOut = st_reg.flag;

  a_set_wins : assert property (@(posedge clk) disable iff (!rst_n)
    setEvt |=> flagOut) else $error("flag not set after event");
endmodule
`default_nettype wire

// ===== tb/pcs_bus_agent.sv
// Purpose: bus agents beside the register block, raising one-cycle error events
// Assumes: bench launches events through evtGo with a mask
// Notes:   mask bit 0 parity .. bit 7 mastership, pulses follow one edge later
`timescale 1ns/1ps
`default_nettype none
module pcs_bus_agent (
  input  wire logic       clk,
  input  wire logic       evtGo,
  input  wire logic [7:0] evtMask,
  output var  logic       parityErrEvt,
  output var  logic       sysErrDetect,
  output var  logic       masterAbortEvt,
  output var  logic       specialCycle,
  output var  logic       targetAbortEvt,
  output var  logic       dataParityErr,
  output var  logic       perrSeen,
  output var  logic       wasMaster
);
  initial {wasMaster, perrSeen, dataParityErr, targetAbortEvt, specialCycle, masterAbortEvt,
           sysErrDetect, parityErrEvt} = 8'h00;
  always @(posedge clk) begin
    {wasMaster, perrSeen, dataParityErr, targetAbortEvt, specialCycle, masterAbortEvt,
     sysErrDetect, parityErrEvt} <= evtGo ? evtMask : 8'h00;
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the command/status and class/revision registers
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes:   reset read and table rows first, then enable, event, pin, set-over-clear and reset cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top;
  import pcs_pkg::*;
  typedef struct packed {
    logic x; logic g; logic [11:0] a; logic [3:0] be; logic [31:0] d; logic [31:0] e;
  } pcs_row_type;
  localparam logic [7:0]  REV    = 8'h5c;  // arbitrary
  localparam logic [31:0] BASEW  = 32'h0230_0000;
  localparam logic [31:0] FBBW   = 32'h0080_0000;
  localparam logic [31:0] CLASSW = {BASE_CLASS_VAL, SUB_CLASS_VAL, PROG_IF_VAL, REV};
  int n_fail = 0;
  int samples_checked = 0;
  logic clk, rst_n, pcixMode, cfgRead, cfgWrite, grpRead, grpWrite, evtGo, seenSe, seenPe;
  logic masterReq, memAccessHit, ioAccessHit, parityErrEvt, sysErrDetect, masterAbortEvt;
  logic specialCycle, targetAbortEvt, dataParityErr, perrSeen, wasMaster;
  logic masterStartOk, memRespond, ioRespond, systemErrorOut, systemErrorOe;
  logic parityErrorOut, parityErrorOe;
  logic [11:0] cfgAddr, grpAddr;
  logic [3:0]  cfgByteEn, grpByteEn;
  logic [7:0]  evtMask;
  logic [31:0] cfgWdata, grpWdata, cfgRdata, grpRdata, r;
  pcs_row_type rows [7] = '{
    '{1'h0, 1'h0, 12'h004, 4'hf, 32'hffff_ffff, 32'h02b0_0146},
    '{1'h0, 1'h1, 12'h004, 4'hf, 32'h0000_0000, 32'h02b0_0000},
    '{1'h1, 1'h0, 12'h004, 4'he, 32'hffff_ffff, 32'h0230_0100},
    '{1'h1, 1'h1, 12'h004, 4'h1, 32'hffff_ffff, 32'h0230_0146},
    '{1'h0, 1'h0, 12'h008, 4'hf, 32'hffff_ffff, CLASSW},
    '{1'h0, 1'h1, 12'h00c, 4'hf, 32'hffff_ffff, 32'h0000_0000},
    '{1'h0, 1'h1, 12'h008, 4'h0, 32'h0000_0000, CLASSW}};
  pcs_cmd_status #(.REVISION_LEVEL(REV)) pcs_cmd_status_i (
    .clk(clk), .rst_n(rst_n), .pcixMode(pcixMode), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
    .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
    .grpRead(grpRead), .grpWrite(grpWrite), .grpAddr(grpAddr), .grpByteEn(grpByteEn),
    .grpWdata(grpWdata), .grpRdata(grpRdata), .parityErrEvt(parityErrEvt),
    .sysErrDetect(sysErrDetect), .masterAbortEvt(masterAbortEvt), .specialCycle(specialCycle),
    .targetAbortEvt(targetAbortEvt), .dataParityErr(dataParityErr), .perrSeen(perrSeen),
    .wasMaster(wasMaster), .masterReq(masterReq), .memAccessHit(memAccessHit),
    .ioAccessHit(ioAccessHit), .masterStartOk(masterStartOk), .memRespond(memRespond),
    .ioRespond(ioRespond), .systemErrorOut(systemErrorOut), .systemErrorOe(systemErrorOe),
    .parityErrorOut(parityErrorOut), .parityErrorOe(parityErrorOe));
  pcs_bus_agent pcs_bus_agent_i (
    .clk(clk), .evtGo(evtGo), .evtMask(evtMask), .parityErrEvt(parityErrEvt),
    .sysErrDetect(sysErrDetect), .masterAbortEvt(masterAbortEvt), .specialCycle(specialCycle),
    .targetAbortEvt(targetAbortEvt), .dataParityErr(dataParityErr), .perrSeen(perrSeen),
    .wasMaster(wasMaster));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // pin drive seen at any point of a test window
  always @(negedge clk) begin
    if (systemErrorOe === 1'h1) seenSe = 1'h1;
    if (parityErrorOe === 1'h1) seenPe = 1'h1;
  end
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic acc(input logic g, input logic w, input logic [11:0] a,
                     input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    {cfgAddr, grpAddr, cfgByteEn, grpByteEn} <= {a, a, be, be};
    {cfgWdata, grpWdata} <= {d, d};
    {cfgRead, cfgWrite, grpRead, grpWrite} <= g ? {2'h0, !w, w} : {!w, w, 2'h0};
    @(posedge clk);
    {cfgRead, cfgWrite, grpRead, grpWrite} <= 4'h0;
    @(negedge clk);
    r = g ? grpRdata : cfgRdata;
  endtask
  task automatic rdchk(input logic g, input logic [11:0] a, input logic [31:0] e);
    acc(g, 1'h0, a, 4'h0, 32'h0);
    `CHK(r, e)
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    {evtGo, evtMask} <= {1'h1, m};
    @(posedge clk);
    evtGo <= 1'h0;
    @(posedge clk);
  endtask
  initial begin
    #2_000_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {rst_n, pcixMode, cfgRead, cfgWrite, grpRead, grpWrite, evtGo} = 7'h0;
    {masterReq, memAccessHit, ioAccessHit, seenSe, seenPe} = 5'h0;
    {cfgAddr, grpAddr, cfgByteEn, grpByteEn, evtMask} = 40'h0;
    {cfgWdata, grpWdata} = 64'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    rdchk(1'h0, CMDSTS_OFFSET, BASEW | FBBW);
    foreach (rows[i]) begin
      @(posedge clk);
      pcixMode <= rows[i].x;
      acc(rows[i].g, 1'h1, rows[i].a, rows[i].be, rows[i].d);
      rdchk(rows[i].g, rows[i].a, rows[i].e);
    end
    $display("register table test done");
    @(posedge clk);
    {masterReq, memAccessHit, ioAccessHit} <= 3'h7;
    repeat (2) @(negedge clk);
    `CHK({masterStartOk, memRespond, ioRespond}, 3'h6)
    acc(1'h0, 1'h1, CMDSTS_OFFSET, 4'hf, 32'h0);
    repeat (2) @(negedge clk);
    `CHK({masterStartOk, memRespond, ioRespond}, 3'h0)
    $display("control enable test done");
    pulse(8'h0c);
    rdchk(1'h0, CMDSTS_OFFSET, BASEW | FBBW);
    pulse(8'h15);
    rdchk(1'h1, CMDSTS_OFFSET, BASEW | FBBW | 32'hb000_0000);
    acc(1'h0, 1'h1, CMDSTS_OFFSET, 4'h7, 32'hffff_fe00);
    rdchk(1'h0, CMDSTS_OFFSET, BASEW | FBBW | 32'hb000_0000);
    acc(1'h1, 1'h1, CMDSTS_OFFSET, 4'h8, 32'hff00_0000);
    rdchk(1'h0, CMDSTS_OFFSET, BASEW | FBBW);
    pulse(8'hc0);
    acc(1'h0, 1'h0, CMDSTS_OFFSET, 4'h0, 32'h0);
    `CHK(r[MDPE_BIT], 1'h0)
    acc(1'h0, 1'h1, CMDSTS_OFFSET, 4'hf, 32'h0000_0040);
    pulse(8'h40);
    pulse(8'h80);
    acc(1'h0, 1'h0, CMDSTS_OFFSET, 4'h0, 32'h0);
    `CHK(r[MDPE_BIT], 1'h0)
    pulse(8'hc0);
    acc(1'h1, 1'h0, CMDSTS_OFFSET, 4'h0, 32'h0);
    `CHK(r[MDPE_BIT], 1'h1)
    $display("event flag test done");
    acc(1'h0, 1'h1, CMDSTS_OFFSET, 4'hf, 32'hff00_0000);
    {seenSe, seenPe} = 2'h0;
    pulse(8'h22);
    repeat (3) @(posedge clk);
    `CHK({seenSe, seenPe}, 2'h0)
    acc(1'h0, 1'h0, CMDSTS_OFFSET, 4'h0, 32'h0);
    `CHK(r[SSE_BIT], 1'h0)
    acc(1'h0, 1'h1, CMDSTS_OFFSET, 4'hf, 32'h0000_0146);
    {seenSe, seenPe} = 2'h0;
    pulse(8'h22);
    repeat (3) @(posedge clk);
    `CHK({seenSe, seenPe, systemErrorOut, parityErrorOut}, 4'hc)
    acc(1'h0, 1'h0, CMDSTS_OFFSET, 4'h0, 32'h0);
    `CHK(r[SSE_BIT], 1'h1)
    $display("error pin test done");
    fork
      pulse(8'h04);
      begin
        @(posedge clk);
        acc(1'h0, 1'h1, CMDSTS_OFFSET, 4'h8, 32'hff00_0000);
      end
    join
    acc(1'h1, 1'h0, CMDSTS_OFFSET, 4'h0, 32'h0);
    `CHK(r[RMA_BIT], 1'h1)
    $display("set over clear test done");
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    `CHK({masterStartOk, memRespond, systemErrorOe, parityErrorOe}, 4'h0)
    rdchk(1'h1, CMDSTS_OFFSET, BASEW | FBBW);
    $display("second reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
